/* File: hdl/bse_handler.sv */
// Status word exception check and service request vector handling
// Behaviour
// - Exception is status AND mask nonzero
// - Mask bits align with status word bits
// - Exception interrupts only when tic selects it
// - Exception halts only when hlt enables it
// - Exception is never a transfer error
// - Both RT-RT status words share one mask
// - Response setting picks which status words checked
// - Tic selects end, error or exception interrupt
// - Hlt selects end, error, exception or any
// - Send mode code 16 when enabled
// - Only first status word triggers vector request
// - Vector word: code, address, subaddress fields
// - Codes 1000/1001 run matching transfer once
// - Codes 1010/1011 append transfer cyclically
// - Codes 1100/1101 remove appended transfer
// - Delete affects only multi-enabled transfers
// - RT-RT transfers never vector driven
// - Count requests per terminal, keep last vector
// - Log each enabled interrupt condition
`timescale 1ns/1ns
module bse_handler
	import bse_pkg::*;
#(
	parameter int NVDT = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Global and per-transfer setup
	input wire logic srq_enable,
	input wire bse_pkg::bse_xfer_cfg_t xfer_cfg,
	input wire bse_pkg::bse_vdt_t [NVDT-1:0] vdt_defs,
	// Transfer events from the sequencer
	input wire bse_pkg::bse_sw_t sw_in,
	input wire logic xfer_end,
	input wire logic xfer_err,
	input wire logic halt_clear,
	// Vector word from the terminal
	input wire logic vec_valid,
	input wire logic vec_err,
	input wire logic [15:0] vec_word,
	// Host read of service request counts
	input wire logic [4:0] srq_rd_rt,
	output logic [SRQ_CNT_W-1:0] srq_rd_cnt,
	output logic [15:0] last_vec,
	// Results
	output logic sw_exception,
	output logic irq,
	output bse_pkg::bse_irq_t irq_cause,
	output logic halt,
	output logic tvw_req,
	output logic [4:0] tvw_rt,
	output logic [4:0] tvw_mode_code,
	output logic exec_once,
	output logic [$clog2(NVDT)-1:0] exec_idx,
	output logic [NVDT-1:0] vdt_active
);
	import bse_pkg::*;

	// Index width and lookup loop are sized for a small table
	if (NVDT < 2 || NVDT > 64) begin : g_nvdt_check
		$error("NVDT out of range");
	end
	// Counters are indexed by the full terminal address field
	if (NUM_RT != 2 ** (SW_RT_MSB - SW_RT_LSB + 1)) begin : g_rt_check
		$error("NUM_RT must cover all terminal addresses");
	end

	// A status word that arrived intact; others take the error path
	function automatic logic sw_usable(input bse_sw_t s);
		return s.valid && !s.word_err;
	endfunction

	// All three conditions must hold before the mode code goes out
	function automatic logic srq_auto_ok(input logic en, input bse_xfer_cfg_t cfg);
		return en && cfg.mask[SW_SRQ_BIT] && cfg.sxh == SXH_SINGLE;
	endfunction

	typedef enum {ST_IDLE, ST_VWAIT} bse_state_t;
	localparam int IW = $clog2(NVDT);

	// Lowest matching predefined transfer; none when found is clear
	function automatic logic [IW:0] vdt_find(input bse_vdt_t [NVDT-1:0] defs,
			input logic [15:0] vw, input logic [1:0] want_sxh);
		logic [IW:0] res;
		res = '0;
		for (int i = NVDT - 1; i >= 0; i--) begin
			if (defs[i].valid && !defs[i].rt_to_rt
					&& defs[i].rt == vw[VW_RT_MSB:VW_RT_LSB]
					&& defs[i].subaddress_or_msg_id == vw[VW_SA_MSB:VW_SA_LSB]
					&& defs[i].tx == vw[VW_ID_LSB]
					&& defs[i].sxh == want_sxh) begin
				res = {1'b1, IW'(i)};
			end
		end
		return res;
	endfunction

	// Reset release: takes effect at once, leaves on the second clock edge
	// so no register sees the release inside its recovery window
	logic rst_s1_reg, rst_s2_reg;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// Main state
	bse_state_t state_reg, state_next;
	logic sx_reg, sx_next;
	logic irq_reg, irq_next;
	bse_irq_t cause_reg, cause_next;
	logic halt_reg, halt_next;
	logic tvw_reg, tvw_next;
	logic [4:0] tvw_rt_reg, tvw_rt_next;
	logic exec_reg, exec_next;
	logic [IW-1:0] exec_idx_reg, exec_idx_next;
	logic [NVDT-1:0] active_reg, active_next;
	logic [15:0] last_vec_reg, last_vec_next;
	logic [SRQ_CNT_W-1:0] cnt_reg [NUM_RT];
	logic [SRQ_CNT_W-1:0] cnt_next [NUM_RT];
	logic [SRQ_CNT_W-1:0] rd_cnt_reg, rd_cnt_next;

	logic [15:0] masked;
	logic checked;
	logic exc;
	logic srq_seen;
	logic [4:0] sw_rt;
	logic [IW:0] hit;
	logic [2:0] vw_code;
	bse_irq_t cause_now;

	// Status word decode shared by all groups
	always_comb begin
		sw_rt = sw_in.word[SW_RT_MSB:SW_RT_LSB];

		// Same mask for either status word of the transfer
		masked = sw_in.word & xfer_cfg.mask;
		case (xfer_cfg.rsp)
			BSE_RSP_SW1: checked = !sw_in.second;
			BSE_RSP_SW2: checked = sw_in.second;
			default: checked = 1'b1;
		endcase
		// Corrupt status words go down the transfer error path instead
		exc = sw_usable(sw_in) && checked && (masked != 16'h0000);
		// Second word of a terminal pair never asks for a vector
		srq_seen = sw_usable(sw_in) && !sw_in.second && sw_in.word[SW_SRQ_BIT];
	end

	// Exception, interrupt and halt
	always_comb begin
		// Exception never feeds the error cause or a retry
		cause_now.end_xfer = xfer_end && xfer_cfg.tic == BSE_TIC_END;
		cause_now.xfer_err = xfer_err && xfer_cfg.tic == BSE_TIC_ERR;
		cause_now.sw_exc = exc && xfer_cfg.tic == BSE_TIC_SX;
		irq_next = |cause_now;
		cause_next = cause_now;
		sx_next = exc;

		// Set wins over the host clear
		halt_next = halt_reg && !halt_clear;
		case (xfer_cfg.hlt)
			BSE_HLT_END: halt_next = halt_next || xfer_end;
			BSE_HLT_ERR: halt_next = halt_next || xfer_err;
			BSE_HLT_SX: halt_next = halt_next || exc;
			BSE_HLT_ANY: halt_next = halt_next || (|cause_now);
			default: halt_next = halt_next;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sx_reg <= 1'b0;
			irq_reg <= 1'b0;
			cause_reg <= '0;
			halt_reg <= 1'b0;
		end else begin
			sx_reg <= sx_next;
			irq_reg <= irq_next;
			cause_reg <= cause_next;
			halt_reg <= halt_next;
		end
	end

	// Service request counters; they wrap, so the host must read often
	always_comb begin
		cnt_next = cnt_reg;
		if (srq_seen) begin
			cnt_next[sw_rt] = cnt_reg[sw_rt] + SRQ_CNT_W'(1);
		end
		rd_cnt_next = cnt_next[srq_rd_rt];
	end

	// Table reset is wide; kept apart from the small state elsewhere
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt_reg <= '0;
			for (int i = 0; i < NUM_RT; i++) begin
				cnt_reg[i] <= '0;
			end
		end else begin
			rd_cnt_reg <= rd_cnt_next;
			cnt_reg <= cnt_next;
		end
	end

	// Vector word request and decode
	always_comb begin
		state_next = state_reg;
		tvw_next = 1'b0;
		tvw_rt_next = tvw_rt_reg;
		exec_next = 1'b0;
		exec_idx_next = exec_idx_reg;
		active_next = active_reg;
		last_vec_next = last_vec_reg;
		hit = '0;
		vw_code = vec_word[VW_ID_MSB:VW_ID_LSB+1];

		case (state_reg)
			ST_IDLE: begin
				if (srq_seen && srq_auto_ok(srq_enable, xfer_cfg)) begin
					tvw_next = 1'b1;
					tvw_rt_next = sw_rt;
					state_next = ST_VWAIT;
				end
			end
			ST_VWAIT: begin
				// Terminal is expected to answer with its vector word
				// Later requests are counted meanwhile but not sent again
				if (xfer_err || (vec_valid && vec_err)) begin
					state_next = ST_IDLE;
				end else if (vec_valid) begin
					state_next = ST_IDLE;
					last_vec_next = vec_word;
					// Unknown codes only leave the word for the host to read
					case (vw_code)
						VW_ID_SINGLE: begin
							hit = vdt_find(vdt_defs, vec_word, SXH_SINGLE);
							exec_next = hit[IW];
							exec_idx_next = hit[IW-1:0];
						end
						VW_ID_MULTI: begin
							hit = vdt_find(vdt_defs, vec_word, SXH_MULTI);
							if (hit[IW]) begin
								active_next[hit[IW-1:0]] = 1'b1;
							end
						end
						VW_ID_DELETE: begin
							// Only transfers that a multi request enabled
							hit = vdt_find(vdt_defs, vec_word, SXH_MULTI);
							if (hit[IW] && active_reg[hit[IW-1:0]]) begin
								active_next[hit[IW-1:0]] = 1'b0;
							end
						end
						default: hit = '0;
					endcase
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			tvw_reg <= 1'b0;
			tvw_rt_reg <= '0;
			exec_reg <= 1'b0;
			exec_idx_reg <= '0;
			active_reg <= '0;
			last_vec_reg <= LAST_VEC_RST;
		end else begin
			state_reg <= state_next;
			tvw_reg <= tvw_next;
			tvw_rt_reg <= tvw_rt_next;
			exec_reg <= exec_next;
			exec_idx_reg <= exec_idx_next;
			active_reg <= active_next;
			last_vec_reg <= last_vec_next;
		end
	end

	// Registered outputs; the mode code is a constant
	assign sw_exception = sx_reg;
	assign irq = irq_reg;
	assign irq_cause = cause_reg;
	assign halt = halt_reg;
	assign tvw_req = tvw_reg;
	assign tvw_rt = tvw_rt_reg;
	assign tvw_mode_code = MC_TX_VECTOR;
	assign exec_once = exec_reg;
	assign exec_idx = exec_idx_reg;
	assign vdt_active = active_reg;
	assign last_vec = last_vec_reg;
	assign srq_rd_cnt = rd_cnt_reg;

endmodule // bse_handler

/* File: hdl/bse_pkg.sv */
// Shared constants and types for the status word exception handler
package bse_pkg;

	// Status word fields
	localparam int SW_RT_MSB = 15;
	localparam int SW_RT_LSB = 11;
	localparam int SW_MSG_ERR_BIT = 10;
	localparam int SW_INSTR_BIT = 9;
	localparam int SW_SRQ_BIT = 8;
	localparam int SW_BUSY_BIT = 3;

	// Vector word fields
	localparam int VW_ID_MSB = 15;
	localparam int VW_ID_LSB = 12;
	localparam int VW_RT_MSB = 11;
	localparam int VW_RT_LSB = 7;
	localparam int VW_SA_MSB = 6;
	localparam int VW_SA_LSB = 0;

	// Vector word request codes; bit 0 selects transmit
	localparam logic [2:0] VW_ID_SINGLE = 3'h4;
	localparam logic [2:0] VW_ID_MULTI = 3'h5;
	localparam logic [2:0] VW_ID_DELETE = 3'h6;

	// Transmit vector word mode code
	localparam logic [4:0] MC_TX_VECTOR = 5'h10;

	// Exception handling settings
	localparam logic [1:0] SXH_NONE = 2'h0;
	localparam logic [1:0] SXH_SINGLE = 2'h1;
	localparam logic [1:0] SXH_MULTI = 2'h2;

	// Reset values and counter sizes
	localparam int NUM_RT = 32;
	localparam int SRQ_CNT_W = 8;
	localparam logic [15:0] LAST_VEC_RST = 16'h0000;

	typedef enum logic [1:0] {BSE_TIC_NONE, BSE_TIC_END, BSE_TIC_ERR, BSE_TIC_SX} bse_tic_t;
	typedef enum logic [2:0] {
		BSE_HLT_NONE, BSE_HLT_END, BSE_HLT_ERR, BSE_HLT_SX, BSE_HLT_ANY
	} bse_hlt_t;
	typedef enum logic [1:0] {BSE_RSP_BOTH, BSE_RSP_SW1, BSE_RSP_SW2} bse_rsp_t;

	// Per-transfer settings supplied by the sequencer
	typedef struct packed {
		logic [15:0] mask;
		bse_tic_t tic;
		bse_hlt_t hlt;
		logic [1:0] sxh;
		bse_rsp_t rsp;
	} bse_xfer_cfg_t;

	// Predefined vector-driven transfer
	typedef struct packed {
		logic valid;
		logic rt_to_rt;
		logic [4:0] rt;
		logic [6:0] subaddress_or_msg_id;
		logic tx;
		logic [1:0] sxh;
	} bse_vdt_t;

	// Received status word event
	typedef struct packed {
		logic valid;
		logic second;
		logic word_err;
		logic [15:0] word;
	} bse_sw_t;

	// Interrupt cause
	typedef struct packed {
		logic end_xfer;
		logic xfer_err;
		logic sw_exc;
	} bse_irq_t;

endpackage

/* File: tb/bse_handler_chk.sv */
// Assertions on the handler ports
`timescale 1ns/1ns
module bse_handler_chk
	import bse_pkg::*;
#(
	parameter int NVDT = 4
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic srq_enable,
	input wire bse_pkg::bse_xfer_cfg_t xfer_cfg,
	input wire bse_pkg::bse_sw_t sw_in,
	input wire logic xfer_end,
	input wire logic xfer_err,
	input wire logic vec_valid,
	input wire logic vec_err,
	input wire logic sw_exception,
	input wire logic irq,
	input wire bse_pkg::bse_irq_t irq_cause,
	input wire logic halt,
	input wire logic tvw_req,
	input wire logic [4:0] tvw_mode_code,
	input wire logic exec_once
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire chk = sw_in.valid && !sw_in.word_err && (xfer_cfg.rsp == BSE_RSP_BOTH
		|| sw_in.second == (xfer_cfg.rsp == BSE_RSP_SW2));
	wire hit = chk && |(sw_in.word & xfer_cfg.mask);
	wire srq = sw_in.valid && !sw_in.second && !sw_in.word_err && sw_in.word[8]
		&& srq_enable && xfer_cfg.mask[8] && xfer_cfg.sxh == SXH_SINGLE;
	property p_exc; hit |=> sw_exception; endproperty
	a_exc: assert property (p_exc) else $error("exception missed");
	property p_noexc; !hit |=> !sw_exception; endproperty
	a_noexc: assert property (p_noexc) else $error("false exception");
	property p_irq; hit && xfer_cfg.tic == BSE_TIC_SX |=> irq && irq_cause.sw_exc; endproperty
	a_irq: assert property (p_irq) else $error("no exception irq");
	property p_halt; hit && xfer_cfg.hlt == BSE_HLT_SX |=> halt; endproperty
	a_halt: assert property (p_halt) else $error("no exception halt");
	property p_noerr; !xfer_err |=> !irq_cause.xfer_err; endproperty
	a_noerr: assert property (p_noerr) else $error("spurious error cause");
	property p_tic; xfer_end && xfer_cfg.tic == BSE_TIC_END |=> irq && irq_cause.end_xfer; endproperty
	a_tic: assert property (p_tic) else $error("no end irq");
	property p_hlt; xfer_err && xfer_cfg.hlt == BSE_HLT_ERR |=> halt; endproperty
	a_hlt: assert property (p_hlt) else $error("no error halt");
	property p_tvw; tvw_req |-> $past(srq) && tvw_mode_code == MC_TX_VECTOR; endproperty
	a_tvw: assert property (p_tvw) else $error("bad vector request");
	property p_exec; exec_once |-> $past(vec_valid) && !$past(vec_err); endproperty
	a_exec: assert property (p_exec) else $error("exec without vector");
endmodule // bse_handler_chk
bind bse_handler bse_handler_chk #(.NVDT(NVDT)) u_chk (.ref_clk, .nrst, .srq_enable,
	.xfer_cfg, .sw_in, .xfer_end, .xfer_err, .vec_valid, .vec_err, .sw_exception, .irq,
	.irq_cause, .halt, .tvw_req, .tvw_mode_code, .exec_once);

/* File: tb/bse_handler_tb.sv */
// Testbench for the status word exception handler
`timescale 1ns/1ns
module bse_handler_tb;
	import bse_pkg::*;
	logic ref_clk = 0, nrst = 0, srq_enable = 0, xfer_end = 0, xfer_err = 0, halt_clear = 0;
	bse_xfer_cfg_t xfer_cfg = '0;
	bse_vdt_t [3:0] vdt_defs;
	bse_sw_t sw_in = '0;
	bse_irq_t irq_cause;
	logic vec_valid, vec_err, sw_exception, irq, halt, tvw_req, exec_once;
	logic [15:0] vec_word, last_vec;
	logic [4:0] srq_rd_rt = 5'h03, tvw_rt, tvw_mode_code;
	logic [7:0] srq_rd_cnt;
	logic [1:0] exec_idx;
	logic [3:0] vdt_active, req_code = 4'h0;
	logic [6:0] req_sa = 7'h00;
	int fails = 0, n_checks = 0, cyc = 0;
	always #50 ref_clk = ~ref_clk;
	assign vdt_defs = {{1'b1, 1'b0, 5'h03, 7'h07, 1'b0, SXH_MULTI},
		{1'b1, 1'b1, 5'h03, 7'h06, 1'b0, SXH_SINGLE},
		{1'b1, 1'b0, 5'h03, 7'h05, 1'b0, SXH_SINGLE},
		{1'b1, 1'b0, 5'h03, 7'h05, 1'b0, SXH_MULTI}};
	bse_handler #(.NVDT(4)) dut (.ref_clk, .nrst, .srq_enable, .xfer_cfg, .vdt_defs, .sw_in,
		.xfer_end, .xfer_err, .halt_clear, .vec_valid, .vec_err, .vec_word, .srq_rd_rt,
		.srq_rd_cnt, .last_vec, .sw_exception, .irq, .irq_cause, .halt, .tvw_req, .tvw_rt,
		.tvw_mode_code, .exec_once, .exec_idx, .vdt_active);
	bse_rt_model #(.DLY(2)) rt (.ref_clk, .tvw_req, .tvw_rt, .tvw_mode_code, .req_code,
		.req_sa, .vec_valid, .vec_err, .vec_word);
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic ck(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cfg(logic [15:0] m, bse_tic_t t, bse_hlt_t h, logic [1:0] s, bse_rsp_t r);
		xfer_cfg = '{m, t, h, s, r};
	endtask
	// Expect {exception, irq, halt, vector request}
	task automatic sw(logic [15:0] w, logic sec, logic er, logic [3:0] x);
		sw_in = '{1'b1, sec, er, w};
		@(negedge ref_clk);
		sw_in = '0;
		ck("sw", x, {sw_exception, irq, halt, tvw_req});
		@(negedge ref_clk);
	endtask
	// Expect {irq, cause, halt}
	task automatic ev(logic e, logic r, logic c, logic [4:0] x);
		{xfer_end, xfer_err, halt_clear} = {e, r, c};
		@(negedge ref_clk);
		{xfer_end, xfer_err, halt_clear} = 3'b000;
		ck("ev", x, {irq, irq_cause, halt});
		@(negedge ref_clk);
	endtask
	task automatic ask(logic [3:0] c, logic [6:0] s, logic [6:0] x);
		req_code = c;
		req_sa = s;
		sw(16'h1900, 0, 0, 4'b1001);
		for (int i = 0; i < 9 && !vec_valid; i++) @(negedge ref_clk);
		ck("vec", x, {exec_once, exec_once ? exec_idx : 2'b00, vdt_active});
		@(negedge ref_clk);
	endtask
	task automatic t_mask;
		cfg(16'h0408, BSE_TIC_SX, BSE_HLT_NONE, SXH_NONE, BSE_RSP_BOTH);
		sw(16'h0008, 0, 0, 4'b1100);
		sw(16'h0400, 0, 0, 4'b1100);
		sw(16'h0200, 0, 0, 4'b0000);
		sw(16'h0408, 0, 1, 4'b0000);
	endtask
	task automatic t_halt;
		cfg(16'h0200, BSE_TIC_NONE, BSE_HLT_SX, SXH_NONE, BSE_RSP_BOTH);
		sw(16'h0200, 0, 0, 4'b1010);
		ev(0, 0, 1, 5'b00000);
		cfg(16'h0200, BSE_TIC_ERR, BSE_HLT_ERR, SXH_NONE, BSE_RSP_BOTH);
		sw(16'h0200, 0, 0, 4'b1000);
		ev(0, 1, 0, 5'b10101);
		ev(0, 0, 1, 5'b00000);
		cfg(16'h0000, BSE_TIC_END, BSE_HLT_ANY, SXH_NONE, BSE_RSP_BOTH);
		ev(1, 0, 0, 5'b11001);
		ev(0, 0, 1, 5'b00000);
	endtask
	task automatic t_rtrt;
		cfg(16'h0400, BSE_TIC_SX, BSE_HLT_NONE, SXH_NONE, BSE_RSP_SW2);
		sw(16'h0400, 0, 0, 4'b0000);
		sw(16'h0400, 1, 0, 4'b1100);
		xfer_cfg.rsp = BSE_RSP_SW1;
		sw(16'h0400, 1, 0, 4'b0000);
		xfer_cfg.rsp = BSE_RSP_BOTH;
		sw(16'h0400, 1, 0, 4'b1100);
	endtask
	task automatic t_srq;
		srq_enable = 1;
		cfg(16'h0100, BSE_TIC_NONE, BSE_HLT_NONE, SXH_SINGLE, BSE_RSP_BOTH);
		ask(4'h8, 7'h05, 7'b1010000);
		ck("last", 16'h8185, last_vec);
		ask(4'ha, 7'h05, 7'b0000001);
		ask(4'hc, 7'h07, 7'b0000001);
		ask(4'h8, 7'h06, 7'b0000001);
		ask(4'hc, 7'h05, 7'b0000000);
		sw(16'h1900, 1, 0, 4'b1000);
		srq_enable = 0;
		sw(16'h1900, 0, 0, 4'b1000);
		ck("cnt", 16'd6, srq_rd_cnt);
		ck("last", 16'hc185, last_vec);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			conclude;
		end
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		nrst = 1;
		repeat (3) @(negedge ref_clk);
		ck("rst", 16'h0010, {halt, vdt_active, tvw_mode_code});
		t_mask;
		t_halt;
		t_rtrt;
		t_srq;
		conclude;
	end
endmodule // bse_handler_tb

/* File: tb/bse_rt_model.sv */
// Remote terminal model answering the vector word mode code
`timescale 1ns/1ns
module bse_rt_model
	import bse_pkg::*;
#(
	parameter int DLY = 2
) (
	// Clock
	input wire logic ref_clk,
	// Mode code request from the handler
	input wire logic tvw_req,
	input wire logic [4:0] tvw_rt,
	input wire logic [4:0] tvw_mode_code,
	// Contents the terminal wants to ask for
	input wire logic [3:0] req_code,
	input wire logic [6:0] req_sa,
	// Vector word back
	output logic vec_valid,
	output logic vec_err,
	output logic [15:0] vec_word
);
	int cnt = 0;
	logic [4:0] rt = 5'h00;
	initial begin
		vec_valid = 1'b0;
		vec_err = 1'b0;
		vec_word = 16'h0000;
	end
	always @(negedge ref_clk) begin
		vec_valid <= 1'b0;
		// Idle line toggles so a stale word is never mistaken for data
		vec_word <= ~vec_word;
		if (tvw_req && tvw_mode_code == MC_TX_VECTOR) begin
			cnt <= DLY;
			rt <= tvw_rt;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
		if (cnt == 1) begin
			vec_valid <= 1'b1;
			vec_word <= {req_code, rt, req_sa};
		end
	end
endmodule // bse_rt_model
